//--- rtl/dfo_pkg.sv
`default_nettype none
package dfo_pkg;
  // =====================================================================
  // register map (offsets are word indices on the plain port)
  localparam logic [3:0] DFO_ADDR_DELTA = 4'h0;
  localparam logic [3:0] DFO_ADDR_OFFSET = 4'h1;
  localparam logic [3:0] DFO_ADDR_CTRL = 4'h2;
  // =====================================================================
  // field layout
  localparam int DFO_VAL_W = 15;
  localparam int DFO_REG_W = 16;
  localparam int DFO_CTRL_OVR = 0;
  localparam int DFO_CTRL_FAST = 1;
  localparam int DFO_CTRL_MODE_LO = 2;
  localparam logic [1:0] DFO_MODE_FREERUN = 2'h3;
  localparam logic [15:0] DFO_DELTA_RST = 16'h0000;
  localparam logic [15:0] DFO_CTRL_RST = 16'h0000;
  // slew step per cycle of the slow path (filter / slope limiter stand-in)
  localparam logic [14:0] DFO_SLEW_STEP = 15'h0001;
  localparam logic [14:0] DFO_ZERO_VAL = 15'h0000;
  // =====================================================================
  // carrier
  typedef struct packed {
    logic ovr_en;
    logic fast_sel;
    logic [1:0] ref_mode;
  } dfo_ctrl_s;
  typedef enum logic [2:0] {
    DFO_ST_IDLE = 3'b001,
    DFO_ST_SLEW = 3'b010,
    DFO_ST_HOLD = 3'b100
  } dfo_state_e;
endpackage
`default_nettype wire

//--- rtl/dfo_slew.sv
`timescale 1ns/10ps
`default_nettype none
module dfo_slew (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [14:0] target,
  input wire logic fast,
  output logic [14:0] present
);
  import dfo_pkg::*;
  // =====================================================================
  // signed slew toward target; fast jumps in one cycle
  logic signed [14:0] tgt_s;
  logic signed [14:0] cur_s;
  assign tgt_s = $signed(target);
  assign cur_s = $signed(present);
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      present <= DFO_ZERO_VAL;
    end else if (fast || present == target) begin
      present <= target;
    end else if (tgt_s > cur_s) begin
      present <= present + DFO_SLEW_STEP;
    end else begin
      present <= present - DFO_SLEW_STEP;
    end
  end
endmodule
`default_nettype wire

//--- rtl/dfo_top.sv
// Summary of operation
// - with override on and freerun mode, delta field is the signed target deviation.
// - fast select applies target at once, else slews step by step.
// - delta ignored when override off or mode not freerun; target returns to zero.
// - offset status bits 14..0 report present signed deviation.
// - offset status bit 15 always reads zero.
// - in fast mode the status need not track a real filtered offset.
// - offset status is read-only; writes leave it unchanged.
`timescale 1ns/10ps
`default_nettype none
module dfo_top (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic [14:0] PRESENT_OFFSET
);
  import dfo_pkg::*;

  // mode is the top field of the control word
  localparam int mode_w = $bits(dfo_ctrl_s) - DFO_CTRL_MODE_LO;

  // =====================================================================
  // bus decode
  // the host port runs on this clock, so strobes are used without a synchroniser
  logic wr_delta;
  logic wr_ctrl;
  logic wr_status;
  logic rd_delta;
  logic rd_status;
  logic rd_ctrl;
  assign wr_delta = WR && ADDR == DFO_ADDR_DELTA;
  assign wr_ctrl = WR && ADDR == DFO_ADDR_CTRL;
  assign wr_status = WR && ADDR == DFO_ADDR_OFFSET;
  assign rd_delta = RD && ADDR == DFO_ADDR_DELTA;
  assign rd_status = RD && ADDR == DFO_ADDR_OFFSET;
  assign rd_ctrl = RD && ADDR == DFO_ADDR_CTRL;

  // =====================================================================
  // software delta register
  logic [14:0] soft_delta_value_q;

  // reserved bit is never stored, so a stray host write cannot leak into the target
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      soft_delta_value_q <= DFO_DELTA_RST[DFO_VAL_W-1:0];
    end else if (wr_delta) begin
      soft_delta_value_q <= WDATA[DFO_VAL_W-1:0];
    end
  end

  a_delta_write: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_delta |=> soft_delta_value_q == $past(WDATA[DFO_VAL_W-1:0]))
    else $error("delta write not stored");

  a_delta_keep: assert property (@(posedge SYS_CLK) disable iff (RST)
    !wr_delta |=> $stable(soft_delta_value_q))
    else $error("delta changed without a write");

  // =====================================================================
  // control bits
  dfo_ctrl_s ctrl_q;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= dfo_ctrl_s'(DFO_CTRL_RST[$bits(dfo_ctrl_s)-1:0]);
    end else if (wr_ctrl) begin
      ctrl_q.ovr_en <= WDATA[DFO_CTRL_OVR];
      ctrl_q.fast_sel <= WDATA[DFO_CTRL_FAST];
      ctrl_q.ref_mode <= WDATA[DFO_CTRL_MODE_LO +: mode_w];
    end
  end

  a_ctrl_write: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_ctrl |=> ctrl_q.ovr_en == $past(WDATA[DFO_CTRL_OVR])
      && ctrl_q.fast_sel == $past(WDATA[DFO_CTRL_FAST]))
    else $error("control write not stored");

  a_mode_write: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_ctrl |=> ctrl_q.ref_mode == $past(WDATA[DFO_CTRL_MODE_LO +: mode_w]))
    else $error("mode field not stored");

  a_ctrl_keep: assert property (@(posedge SYS_CLK) disable iff (RST)
    !wr_ctrl |=> $stable(ctrl_q))
    else $error("control changed without a write");

  a_status_ro: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_status |=> $stable(soft_delta_value_q) && $stable(ctrl_q))
    else $error("write to status changed state");

  // =====================================================================
  // target selection
  logic apply_soft;
  logic [14:0] target_d;
  logic [14:0] present_offset_value;

  assign apply_soft = ctrl_q.ovr_en && ctrl_q.ref_mode == DFO_MODE_FREERUN;
  // other modes belong to the loop proper; here they just settle to centre
  assign target_d = apply_soft ? soft_delta_value_q : DFO_ZERO_VAL;

  // =====================================================================
  // offset tracking
  // unit steps stand in for filter and slope limiter; settling time is not the real loop's
  dfo_slew u_slew (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .target(target_d),
    .fast(ctrl_q.fast_sel),
    .present(present_offset_value)
  );

  a_fast_jump: assert property (@(posedge SYS_CLK) disable iff (RST)
    ctrl_q.fast_sel |=> present_offset_value == $past(target_d))
    else $error("fast mode did not jump to target");

  a_freerun_use: assert property (@(posedge SYS_CLK) disable iff (RST)
    (apply_soft && ctrl_q.fast_sel) |=> present_offset_value == $past(soft_delta_value_q))
    else $error("freerun override target not applied");

  a_ignore_delta: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!apply_soft && ctrl_q.fast_sel) |=> present_offset_value == DFO_ZERO_VAL)
    else $error("delta used outside override freerun");

  a_ignore_slow: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!apply_soft && present_offset_value == DFO_ZERO_VAL) |=> present_offset_value == DFO_ZERO_VAL)
    else $error("centre left outside override freerun");

  a_slow_step: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!ctrl_q.fast_sel && present_offset_value != target_d) |=>
      present_offset_value != $past(present_offset_value))
    else $error("slow path stalled");

  a_slow_up: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!ctrl_q.fast_sel && $signed(present_offset_value) < $signed(target_d)) |=>
      present_offset_value == $past(present_offset_value) + DFO_SLEW_STEP)
    else $error("slow path did not step up");

  a_slow_down: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!ctrl_q.fast_sel && $signed(present_offset_value) > $signed(target_d)) |=>
      present_offset_value == $past(present_offset_value) - DFO_SLEW_STEP)
    else $error("slow path did not step down");

  a_settled_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
    (present_offset_value == target_d) |=> present_offset_value == $past(target_d))
    else $error("settled offset moved");

  a_status_keep: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_status && present_offset_value == target_d) |=>
      present_offset_value == $past(present_offset_value))
    else $error("status write moved the offset");

  // =====================================================================
  // tracking phase
  // watched by the checks only; the register map has no phase field, though the control word leaves bits 15..4 spare
  dfo_state_e phase_q;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      phase_q <= DFO_ST_IDLE;
    end else begin
      case (phase_q)
        DFO_ST_IDLE: begin
          if (ctrl_q.fast_sel) begin
            phase_q <= DFO_ST_HOLD;
          end else if (present_offset_value != target_d) begin
            phase_q <= DFO_ST_SLEW;
          end
        end
        DFO_ST_SLEW: begin
          if (ctrl_q.fast_sel) begin
            phase_q <= DFO_ST_HOLD;
          end else if (present_offset_value == target_d) begin
            phase_q <= DFO_ST_IDLE;
          end
        end
        DFO_ST_HOLD: begin
          if (!ctrl_q.fast_sel) begin
            phase_q <= DFO_ST_IDLE;
          end
        end
        default: begin
          phase_q <= DFO_ST_IDLE;
        end
      endcase
    end
  end

  a_hold_exact: assert property (@(posedge SYS_CLK) disable iff (RST)
    (phase_q == DFO_ST_HOLD) |-> present_offset_value == $past(target_d))
    else $error("fast hold left the target");

  // =====================================================================
  // status copy on the pin
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PRESENT_OFFSET <= DFO_ZERO_VAL;
    end else begin
      PRESENT_OFFSET <= present_offset_value;
    end
  end

  a_status_mirror: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1 |=> PRESENT_OFFSET == $past(present_offset_value))
    else $error("offset pin does not follow status");

  // =====================================================================
  // read port; writes to the status offset are dropped
  // data stand for each cycle after one with RD high, zero otherwise, so a late sample cannot see stale data
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= DFO_DELTA_RST;
    end else if (RD) begin
      case (ADDR)
        DFO_ADDR_DELTA: RDATA <= {1'b0, soft_delta_value_q};
        DFO_ADDR_OFFSET: RDATA <= {1'b0, present_offset_value};
        DFO_ADDR_CTRL: RDATA <= {{(DFO_REG_W - $bits(dfo_ctrl_s)){1'b0}},
          ctrl_q.ref_mode, ctrl_q.fast_sel, ctrl_q.ovr_en};
        default: RDATA <= DFO_DELTA_RST;
      endcase
    end else begin
      RDATA <= DFO_DELTA_RST;
    end
  end

  a_status_read: assert property (@(posedge SYS_CLK) disable iff (RST)
    rd_status |=> RDATA[DFO_VAL_W-1:0] == $past(present_offset_value))
    else $error("status read wrong value");

  a_bit15_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    $past(rd_status) |-> !RDATA[DFO_REG_W-1])
    else $error("status bit 15 set");

  a_delta_rsvd: assert property (@(posedge SYS_CLK) disable iff (RST)
    rd_delta |=> !RDATA[DFO_REG_W-1])
    else $error("delta bit 15 set");

  a_delta_read: assert property (@(posedge SYS_CLK) disable iff (RST)
    rd_delta |=> RDATA == {1'b0, $past(soft_delta_value_q)})
    else $error("delta read wrong value");

  a_ctrl_read: assert property (@(posedge SYS_CLK) disable iff (RST)
    rd_ctrl |=> RDATA[DFO_CTRL_OVR] == $past(ctrl_q.ovr_en)
      && RDATA[DFO_CTRL_FAST] == $past(ctrl_q.fast_sel))
    else $error("control read wrong value");

  a_rdata_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
    !RD |=> RDATA == DFO_DELTA_RST)
    else $error("read data not cleared");
endmodule
`default_nettype wire

//--- tb/tb_dfo_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_dfo_top;
  import dfo_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] RDATA;
  logic [14:0] PRESENT_OFFSET;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  dfo_top dfo_top_inst (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PRESENT_OFFSET(PRESENT_OFFSET));
  // ==========================================================
  // clock, timeout
  initial begin
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // bus tasks
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge SYS_CLK) begin ADDR <= a; WDATA <= d; WR <= 1'b1; end
    @(posedge SYS_CLK) WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge SYS_CLK) begin ADDR <= a; RD <= 1'b1; end
    @(posedge SYS_CLK) RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_and_map();
    logic [15:0] d;
    rd(DFO_ADDR_DELTA, d); `CHK(d, DFO_DELTA_RST)
    rd(DFO_ADDR_OFFSET, d); `CHK(d, 16'h0000)
    rd(4'hF, d); `CHK(d, 16'h0000)
    wr(DFO_ADDR_DELTA, 16'h0005);
    rd(DFO_ADDR_DELTA, d); `CHK(d, 16'h0005)
  endtask
  task automatic t_fast_and_readonly();
    logic [15:0] d;
    wr(DFO_ADDR_CTRL, 16'h000F);
    idle(4);
    rd(DFO_ADDR_OFFSET, d); `CHK(d, 16'h0005)
    wr(DFO_ADDR_OFFSET, 16'h1234);
    rd(DFO_ADDR_OFFSET, d); `CHK(d, 16'h0005)
  endtask
  task automatic t_slow_negative();
    logic [15:0] d;
    // slow path walks one step per cycle, so -5 from +5 cannot land at once
    wr(DFO_ADDR_CTRL, 16'h000D);
    wr(DFO_ADDR_DELTA, 16'h7FFB);
    rd(DFO_ADDR_OFFSET, d); `CHK(d, 16'h0004)
    idle(30);
    rd(DFO_ADDR_OFFSET, d); `CHK(d, 16'h7FFB)
    `CHK(PRESENT_OFFSET, 15'h7FFB)
    wr(DFO_ADDR_DELTA, 16'h0003);
    idle(20);
    rd(DFO_ADDR_OFFSET, d); `CHK(d, 16'h0003)
  endtask
  task automatic t_ignored();
    logic [15:0] d;
    logic [15:0] ctl [2] = '{16'h0007, 16'h000E};
    foreach (ctl[i]) begin
      wr(DFO_ADDR_CTRL, 16'h000F);
      idle(4);
      wr(DFO_ADDR_CTRL, ctl[i]);
      idle(40);
      rd(DFO_ADDR_OFFSET, d); `CHK(d, 16'h0000)
    end
  endtask
  // ==========================================================
  // main sequence and verdict
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    idle(20);
    RST <= 1'b0;
    t_reset_and_map();
    t_fast_and_readonly();
    t_slow_negative();
    t_ignored();
    tally_and_finish();
  end
endmodule
`default_nettype wire
